// *** eoc_pkg.sv ***
// External oscillator control: shared constants, state type and mode decode.
// Assumes an 8-bit special-function register bus with address and page.
package eoc_pkg;

  // Register location and width
  localparam logic [7:0] SFR_ADDR_CTRL = 8'h9F; // Control register address
  localparam logic [7:0] SFR_PAGE_CTRL = 8'h0F; // Control register page
  localparam int DATA_W = 8;                      // Register width
  localparam logic [7:0] CTRL_RESET = 8'h00;     // Reset value, circuit off

  // Field positions
  localparam int VALID_BIT = 7;   // Crystal valid flag, read only
  localparam int MODE_MSB = 6;    // Mode field top
  localparam int MODE_LSB = 4;    // Mode field bottom
  localparam int UNUSED_BIT = 3;  // Always reads zero
  localparam int BAND_MSB = 2;    // Drive band top
  localparam int BAND_LSB = 0;    // Drive band bottom

  // Mode codes
  localparam logic [2:0] MODE_OFF = 3'h0;      // Circuit off
  localparam logic [2:0] MODE_RSVD = 3'h1;     // Unassigned, treated as off
  localparam logic [2:0] MODE_CMOS = 3'h2;     // External CMOS clock
  localparam logic [2:0] MODE_CMOS_D2 = 3'h3;  // CMOS clock divided by 2
  localparam logic [2:0] MODE_RC = 3'h4;       // RC oscillator
  localparam logic [2:0] MODE_CAP = 3'h5;      // Capacitor oscillator
  localparam logic [2:0] MODE_XTAL = 3'h6;     // Crystal oscillator
  localparam logic [2:0] MODE_XTAL_D2 = 3'h7;  // Crystal divided by 2

  // Pin synchroniser depth
  localparam int SYNC_W = 3;

  // Crystal qualification states, one-hot
  typedef enum logic [2:0] {
    XS_OFF = 3'h1,
    XS_START = 3'h2,
    XS_RUN = 3'h4
  } eoc_xstate_t;

  // Crystal modes are the codes 11x
  function automatic logic eocIsCrystal(input logic [2:0] mode);
    eocIsCrystal = (mode == MODE_XTAL) || (mode == MODE_XTAL_D2);
  endfunction

  // Modes with the divide-by-2 stage
  function automatic logic eocIsDiv2(input logic [2:0] mode);
    eocIsDiv2 = (mode == MODE_CMOS_D2) || (mode == MODE_XTAL_D2);
  endfunction

  // Any mode that powers the drive circuit
  function automatic logic eocIsOn(input logic [2:0] mode);
    eocIsOn = (mode != MODE_OFF) && (mode != MODE_RSVD);
  endfunction

endpackage

// *** eoc_clk_path.sv ***
// External oscillator clock path: samples the oscillator pin level and
// passes it on, either undivided or halved by a toggle stage.
// Assumes the oscillator runs well below half the system clock rate.
`timescale 1ns/1ps
`default_nettype none
module eoc_clk_path
  import eoc_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Oscillator pin and control
  input wire logic oscPinRaw,
  input wire logic pathEnable,
  input wire logic pathDiv2,
  // Delivered clock
  output logic extClk
);

  logic [SYNC_W-1:0] sync_q, sync_d; // Three-stage pin synchroniser
  logic level_q, level_d;            // Filtered pin level
  logic extClk_q, extClk_d;          // Delivered clock register
  logic levelRise;                   // Filtered rising edge

  // Level changes only once stages two and three agree
  assign levelRise = (sync_q[2] == sync_q[1]) && sync_q[2] && !level_q;

  // Next-value logic
  always_comb begin
    sync_d = {sync_q[1:0], oscPinRaw};
    level_d = (sync_q[2] == sync_q[1]) ? sync_q[2] : level_q;
    if (!pathEnable) begin
      // Circuit off: hold low
      extClk_d = 1'b0;
    end else if (pathDiv2) begin
      // Toggle once per incoming period
      extClk_d = levelRise ? !extClk_q : extClk_q;
    end else begin
      // Undivided: follow the pin
      extClk_d = level_d;
    end
  end

  // Registers, frozen while ce is low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_q <= '0;
      level_q <= 1'b0;
      extClk_q <= 1'b0;
    end else if (ce) begin
      sync_q <= sync_d;
      level_q <= level_d;
      extClk_q <= extClk_d;
    end
  end

  assign extClk = extClk_q;

  // Halving stage toggles on every incoming rising edge
  property p_div2Toggle;
    @(posedge clk) disable iff (!rst_b)
      ce && pathEnable && pathDiv2 && levelRise |=> extClk_q != $past(extClk_q);
  endproperty
  a_div2Toggle: assert property (p_div2Toggle) else $error("div2 missed toggle");

  // Halving stage holds between incoming rising edges
  property p_div2Hold;
    @(posedge clk) disable iff (!rst_b)
      ce && pathEnable && pathDiv2 && !levelRise |=> $stable(extClk_q);
  endproperty
  a_div2Hold: assert property (p_div2Hold) else $error("div2 toggled early");

  // Undivided path tracks the filtered level
  property p_passThrough;
    @(posedge clk) disable iff (!rst_b)
      ce && pathEnable && !pathDiv2 |=> extClk_q == level_q;
  endproperty
  a_passThrough: assert property (p_passThrough) else $error("clock not passed");

  // Halved clock actually toggles
  c_div2Run: cover property (@(posedge clk) disable iff (!rst_b)
    pathDiv2 && levelRise ##1 extClk_q);

endmodule
`default_nettype wire

// *** eoc_top.sv ***
// External oscillator control block: the control register on the
// special-function bus, crystal qualification and clock delivery.
// Assumes the analog drive circuit and amplitude detector sit outside.
`timescale 1ns/1ps
`default_nettype none
module eoc_top
  import eoc_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Special-function register bus
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrPage,
  input wire logic sfrWrEn,
  input wire logic [eoc_pkg::DATA_W-1:0] sfrWrData,
  input wire logic sfrRdEn,
  output logic [eoc_pkg::DATA_W-1:0] sfrRdData,
  // Analog oscillator interface
  input wire logic xtalStableRaw,
  input wire logic oscPinRaw,
  output logic [2:0] oscModeSelect,
  output logic [2:0] oscDriveBand,
  output logic oscCircuitEnable,
  // Status and pin claims
  output logic crystalValidFlag,
  output logic crystalPinInClaim,
  output logic crystalPinOutClaim,
  // Delivered external clock
  output logic extClk
);

  // Control fields
  logic [2:0] mode_q, mode_d;           // Oscillator mode field
  logic [2:0] band_q, band_d;           // Drive band field
  logic [DATA_W-1:0] rdData_q, rdData_d; // Registered read data
  // Amplitude detector synchroniser
  logic [SYNC_W-1:0] stSync_q, stSync_d; // Three-stage synchroniser
  logic stable_q, stable_d;              // Filtered stable level
  // Crystal qualification
  eoc_xstate_t xstate_q, xstate_d;       // Qualification state
  // Decode
  logic regHit;                          // Address and page match
  logic isXtal;                          // Current mode is crystal
  logic validNow;                        // Flag value this cycle
  logic [DATA_W-1:0] readWord;           // Assembled read value

  // Address and page decode
  assign regHit = (sfrAddr == SFR_ADDR_CTRL) && (sfrPage == SFR_PAGE_CTRL);
  assign isXtal = eocIsCrystal(mode_q);
  // Flag is set only in crystal modes after qualification
  assign validNow = isXtal && (xstate_q == XS_RUN);

  // Read value assembly
  always_comb begin
    readWord = '0;
    readWord[VALID_BIT] = validNow;
    readWord[MODE_MSB:MODE_LSB] = mode_q;
    readWord[UNUSED_BIT] = 1'b0;
    readWord[BAND_MSB:BAND_LSB] = band_q;
  end

  // Register file next values
  always_comb begin
    mode_d = mode_q;
    band_d = band_q;
    rdData_d = rdData_q;
    if (sfrWrEn && regHit) begin
      // Bits 7 and 3 are not stored
      mode_d = sfrWrData[MODE_MSB:MODE_LSB];
      band_d = sfrWrData[BAND_MSB:BAND_LSB];
    end
    if (sfrRdEn) begin
      // Unmapped reads return zero
      rdData_d = regHit ? readWord : '0;
    end
  end

  // Register file state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // Everything off after reset
      mode_q <= CTRL_RESET[MODE_MSB:MODE_LSB];
      band_q <= CTRL_RESET[BAND_MSB:BAND_LSB];
      rdData_q <= CTRL_RESET;
    end else if (ce) begin
      mode_q <= mode_d;
      band_q <= band_d;
      rdData_q <= rdData_d;
    end
  end

  // Synchroniser and qualification next values
  always_comb begin
    stSync_d = {stSync_q[1:0], xtalStableRaw};
    // Change counts once stages two and three agree
    stable_d = (stSync_q[2] == stSync_q[1]) ? stSync_q[2] : stable_q;
    if (!eocIsOn(mode_q)) begin
      // Circuit off: forget old amplitude so a restart settles anew
      stSync_d = '0;
      stable_d = 1'b0;
    end
    xstate_d = xstate_q;
    case (xstate_q)
      XS_OFF: begin
        // Wait for a crystal mode
        if (isXtal) begin
          xstate_d = XS_START;
        end
      end
      XS_START: begin
        // Settling: flag stays low until amplitude is stable
        if (!isXtal) begin
          xstate_d = XS_OFF;
        end else if (stable_q) begin
          xstate_d = XS_RUN;
        end
      end
      XS_RUN: begin
        // Loss of amplitude or leaving the crystal modes drops the flag
        if (!isXtal) begin
          xstate_d = XS_OFF;
        end else if (!stable_q) begin
          xstate_d = XS_START;
        end
      end
      default: begin
        xstate_d = XS_OFF;
      end
    endcase
  end

  // Synchroniser and qualification state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stSync_q <= '0;
      stable_q <= 1'b0;
      xstate_q <= XS_OFF;
    end else if (ce) begin
      stSync_q <= stSync_d;
      stable_q <= stable_d;
      xstate_q <= xstate_d;
    end
  end

  // Clock delivery path
  eoc_clk_path u_clkPath (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .oscPinRaw(oscPinRaw),
    .pathEnable(eocIsOn(mode_q)),
    .pathDiv2(eocIsDiv2(mode_q)),
    .extClk(extClk)
  );

  // Outputs from register state
  assign sfrRdData = rdData_q;
  assign oscModeSelect = mode_q;
  assign oscDriveBand = band_q;
  assign oscCircuitEnable = eocIsOn(mode_q);
  assign crystalValidFlag = validNow;
  assign crystalPinInClaim = isXtal;
  assign crystalPinOutClaim = eocIsOn(mode_q);

  // Mapped write updates the mode field
  property p_modeWrite;
    @(posedge clk) disable iff (!rst_b)
      ce && sfrWrEn && regHit |=> mode_q == $past(sfrWrData[MODE_MSB:MODE_LSB]);
  endproperty
  a_modeWrite: assert property (p_modeWrite) else $error("mode not written");

  // Writes elsewhere leave the register alone
  property p_missWrite;
    @(posedge clk) disable iff (!rst_b)
      ce && sfrWrEn && !regHit |=> $stable(mode_q) && $stable(band_q);
  endproperty
  a_missWrite: assert property (p_missWrite) else $error("stray write took");

  // Mapped write updates the drive band
  property p_bandWrite;
    @(posedge clk) disable iff (!rst_b)
      ce && sfrWrEn && regHit |=> band_q == $past(sfrWrData[BAND_MSB:BAND_LSB]);
  endproperty
  a_bandWrite: assert property (p_bandWrite) else $error("band not written");

  // Read returns band and mode one cycle later
  property p_readBack;
    @(posedge clk) disable iff (!rst_b)
      ce && sfrRdEn && regHit |=>
        sfrRdData[BAND_MSB:BAND_LSB] == $past(band_q) &&
        sfrRdData[MODE_MSB:MODE_LSB] == $past(mode_q);
  endproperty
  a_readBack: assert property (p_readBack) else $error("read data wrong");

  // Unused bit never reads as one
  property p_unusedZero;
    @(posedge clk) disable iff (!rst_b)
      sfrRdData[UNUSED_BIT] == 1'b0;
  endproperty
  a_unusedZero: assert property (p_unusedZero) else $error("unused bit set");

  // Flag only in crystal modes, and only after stable amplitude
  property p_flagCause;
    @(posedge clk) disable iff (!rst_b)
      $rose(crystalValidFlag) |-> isXtal && $past(stable_q);
  endproperty
  a_flagCause: assert property (p_flagCause) else $error("flag without cause");

  // Flag reads back through the bus
  property p_flagRead;
    @(posedge clk) disable iff (!rst_b)
      ce && sfrRdEn && regHit |=> sfrRdData[VALID_BIT] == $past(validNow);
  endproperty
  a_flagRead: assert property (p_flagRead) else $error("flag read wrong");

  // Pin claims follow the mode
  property p_pinClaim;
    @(posedge clk) disable iff (!rst_b)
      crystalPinInClaim == (mode_q[2] && mode_q[1]) &&
      crystalPinOutClaim == (mode_q != MODE_OFF && mode_q != MODE_RSVD);
  endproperty
  a_pinClaim: assert property (p_pinClaim) else $error("pin claim wrong");

  // Scenarios of interest
  c_xtalRun: cover property (@(posedge clk) disable iff (!rst_b)
    xstate_q == XS_START ##[1:20] xstate_q == XS_RUN);
  c_regWrite: cover property (@(posedge clk) disable iff (!rst_b)
    ce && sfrWrEn && regHit ##1 ce && sfrRdEn && regHit);
  c_flagDrop: cover property (@(posedge clk) disable iff (!rst_b)
    crystalValidFlag ##1 !crystalValidFlag);

endmodule
`default_nettype wire

// *** eoc_osc_model.sv ***
// External oscillator partner: a free-running source on the pin.
// Assumes the drive enable comes straight from the block under test.
`timescale 1ns/1ps
`default_nettype none
module eoc_osc_model #(
  parameter int HALF_NS = 17,  // Half period, over 3 system clocks
  parameter int START_NS = 80  // Amplitude settling time
) (
  // Drive enable from the block
  input wire logic enable,
  // Pin level and amplitude detector
  output logic pinLevel,
  output logic stable
);
  // Pin forced high by software before the drive starts
  initial begin
    pinLevel = 1'b1;
    stable = 1'b0;
  end
  // Oscillates only while driven, else pin stands high
  always begin
    #(HALF_NS);
    pinLevel = enable ? ~pinLevel : 1'b1;
  end
  // Amplitude settles some time after power-up
  always @(posedge enable) begin
    #(START_NS);
    stable = enable;
  end
  // Drops at once when the drive stops
  always @(negedge enable) begin
    stable = 1'b0;
  end
endmodule
`default_nettype wire

// *** external_oscillator_control_tb.sv ***
// Testbench for the external oscillator control block.
// Assumes the oscillator partner model and the block's package.
`timescale 1ns/1ps
`default_nettype none
module external_oscillator_control_tb;
  import eoc_pkg::*;
  // Clock, reset and bus drive
  logic clk = 1'b0;
  logic rstB = 1'b0;
  logic ce = 1'b1;
  logic [7:0] sfrAddr = 8'h00;
  logic [7:0] sfrPage = 8'h00;
  logic sfrWrEn = 1'b0;
  logic [7:0] sfrWrData = 8'h00;
  logic sfrRdEn = 1'b0;
  // Block outputs
  logic [7:0] sfrRdData;
  logic [2:0] oscModeSelect;
  logic [2:0] oscDriveBand;
  logic oscCircuitEnable, crystalValidFlag, pinInClaim, pinOutClaim, extClk;
  // Partner pins
  logic oscPin, xtalStable;
  // Counters and random state
  int errorCnt = 0;
  int checkCount = 0;
  logic [7:0] rnd = 8'h46;
  logic [7:0] rd;
  int edges;
  // Behavioural register model
  int mdlMode = 0;
  int mdlBand = 0;

  // Clock at 250 MHz
  always #2 clk = ~clk;

  eoc_top dut (.clk(clk), .rst_b(rstB), .ce(ce), .sfrAddr(sfrAddr), .sfrPage(sfrPage),
    .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
    .xtalStableRaw(xtalStable), .oscPinRaw(oscPin), .oscModeSelect(oscModeSelect),
    .oscDriveBand(oscDriveBand), .oscCircuitEnable(oscCircuitEnable),
    .crystalValidFlag(crystalValidFlag), .crystalPinInClaim(pinInClaim),
    .crystalPinOutClaim(pinOutClaim), .extClk(extClk));

  eoc_osc_model osc (.enable(oscCircuitEnable), .pinLevel(oscPin), .stable(xtalStable));

  // Random source
  function automatic logic [7:0] lfsrNext(input logic [7:0] s);
    lfsrNext = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Model read word with the expected flag
  function automatic logic [7:0] mdlWord(input int flag);
    mdlWord = {flag[0], mdlMode[2:0], 1'b0, mdlBand[2:0]};
  endfunction

  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errorCnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and stop
  task automatic end_of_test();
    $display("checks %0d errors %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One-cycle write strobe
  task automatic sfrWrite(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
    @(negedge clk);
    sfrAddr = a;
    sfrPage = p;
    sfrWrData = d;
    sfrWrEn = 1'b1;
    @(negedge clk);
    sfrWrEn = 1'b0;
    // Model takes only enabled writes that hit
    if (ce && a == SFR_ADDR_CTRL && p == SFR_PAGE_CTRL) begin
      mdlMode = d[MODE_MSB:MODE_LSB];
      mdlBand = d[BAND_MSB:BAND_LSB];
    end
  endtask

  // One-cycle read strobe, data one cycle later
  task automatic sfrRead(input logic [7:0] a, input logic [7:0] p, output logic [7:0] d);
    @(negedge clk);
    sfrAddr = a;
    sfrPage = p;
    sfrRdEn = 1'b1;
    @(negedge clk);
    sfrRdEn = 1'b0;
    d = sfrRdData;
  endtask

  // Rising edges of the delivered clock over 340 cycles
  task automatic countEdges(output int n);
    logic prev;
    n = 0;
    prev = extClk;
    repeat (340) begin
      @(negedge clk);
      if (extClk && !prev) n++;
      prev = extClk;
    end
  endtask

  // Main sequence
  initial begin
    int mode, band, exp;
    logic [7:0] expv;
    repeat (4) @(negedge clk);
    rstB = 1'b1;
    sfrRead(SFR_ADDR_CTRL, SFR_PAGE_CTRL, rd);
    check(rd, 8'h00);
    // Every mode with a random band and noise in bits 7 and 3
    for (mode = 0; mode < 8; mode++) begin
      rnd = lfsrNext(rnd);
      band = rnd[2:0];
      sfrWrite(SFR_ADDR_CTRL, SFR_PAGE_CTRL, {rnd[7], mode[2:0], rnd[3], rnd[2:0]});
      repeat (40) @(negedge clk);
      sfrRead(SFR_ADDR_CTRL, SFR_PAGE_CTRL, rd);
      check(rd, {mode >= 6, mode[2:0], 1'b0, band[2:0]});
      check({1'b0, oscModeSelect, 1'b0, oscDriveBand}, {1'b0, mode[2:0], 1'b0, band[2:0]});
      check(rd, mdlWord(mode >= 6));
      check({7'h00, crystalValidFlag}, {7'h00, mode >= 6});
      expv = {5'h00, mode > 1, mode >= 6, mode > 1};
      check({5'h00, oscCircuitEnable, pinInClaim, pinOutClaim}, expv);
      exp = (mode < 2) ? 0 : ((mode == 3 || mode == 7) ? 20 : 40);
      countEdges(edges);
      expv = {7'h00, (exp == 0) ? edges == 0 : (edges >= exp - 1 && edges <= exp + 1)};
      check(expv, 8'h01);
    end
    // Crystal start-up: flag low until settled, band lowered after
    sfrWrite(SFR_ADDR_CTRL, SFR_PAGE_CTRL, 8'h00);
    sfrWrite(SFR_ADDR_CTRL, SFR_PAGE_CTRL, 8'h61);
    sfrRead(SFR_ADDR_CTRL, SFR_PAGE_CTRL, rd);
    check(rd, 8'h61);
    repeat (40) @(negedge clk);
    sfrRead(SFR_ADDR_CTRL, SFR_PAGE_CTRL, rd);
    check(rd, 8'hE1);
    check({7'h00, crystalValidFlag}, 8'h01);
    sfrWrite(SFR_ADDR_CTRL, SFR_PAGE_CTRL, 8'h60);
    sfrRead(SFR_ADDR_CTRL, SFR_PAGE_CTRL, rd);
    check(rd, 8'hE0);
    // Writes with the clock enable low are frozen out
    ce = 1'b0;
    sfrWrite(SFR_ADDR_CTRL, SFR_PAGE_CTRL, 8'h20);
    ce = 1'b1;
    sfrRead(SFR_ADDR_CTRL, SFR_PAGE_CTRL, rd);
    check(rd, mdlWord(1));
    // Off-address and off-page traffic
    sfrWrite(8'h9E, SFR_PAGE_CTRL, 8'h55);
    sfrWrite(SFR_ADDR_CTRL, 8'h00, 8'h55);
    sfrRead(SFR_ADDR_CTRL, SFR_PAGE_CTRL, rd);
    check(rd, 8'hE0);
    check(rd, mdlWord(1));
    sfrRead(8'h9E, SFR_PAGE_CTRL, rd);
    check(rd, 8'h00);
    sfrRead(SFR_ADDR_CTRL, 8'h0E, rd);
    check(rd, 8'h00);
    // Reset in mid-run returns everything to off
    rstB = 1'b0;
    repeat (4) @(negedge clk);
    rstB = 1'b1;
    mdlMode = 0;
    mdlBand = 0;
    sfrRead(SFR_ADDR_CTRL, SFR_PAGE_CTRL, rd);
    check(rd, mdlWord(0));
    check({6'h00, crystalValidFlag, extClk}, 8'h00);
    end_of_test();
  end

  // Watchdog well past the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    errorCnt++;
    end_of_test();
  end
endmodule
`default_nettype wire
